// *** core/pmc_pkg.sv ***
package pmc_pkg;
  // global power modes, in order of decreasing consumption
  typedef enum logic [1:0]
  {
    PMC_ACTIVE = 2'h0,
    PMC_ALT_ACTIVE = 2'h1,
    PMC_SLEEP = 2'h2,
    PMC_HIBERNATE = 2'h3
  } pmc_mode_t;

  // mode request codes written by firmware (3 bits, codes above 3 unsupported)
  localparam logic [2:0] PMC_REQ_ACTIVE = 3'h0;
  localparam logic [2:0] PMC_REQ_ALT = 3'h1;
  localparam logic [2:0] PMC_REQ_SLEEP = 3'h2;
  localparam logic [2:0] PMC_REQ_HIB = 3'h3;

  localparam int PMC_NUM_SUBSYS = 8;
  localparam int PMC_CPU_BIT = 0;
  localparam logic [7:0] PMC_TEMPLATE_RST = 8'hFF;

  // sleep wakeup source indices
  localparam int PMC_WK_CMP = 0;
  localparam int PMC_WK_PIU = 1;
  localparam int PMC_WK_I2C = 2;
  localparam int PMC_WK_RTC = 3;
  localparam int PMC_WK_CTW = 4;
  localparam int PMC_WK_LVD = 5;
  localparam int PMC_NUM_WK = 6;

  // timing
  localparam int PMC_CLK_MHZ = 20;
  localparam int PMC_SLEEP_RESUME_US = 25;
  localparam int PMC_HIB_RESUME_US = 200;
  // longest times round down
  localparam int PMC_SLEEP_RESUME_CYC = PMC_SLEEP_RESUME_US * PMC_CLK_MHZ - 1;
  localparam int PMC_HIB_RESUME_CYC = PMC_HIB_RESUME_US * PMC_CLK_MHZ - 1;
  // regulator buzz period (on one cycle out of this many)
  localparam int PMC_BUZZ_PERIOD = 16;
  localparam int PMC_CNT_W = 13;
endpackage

// *** core/pmc_sync.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; output changes when stages two and three agree
module pmc_sync
  import pmc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_mclk)
      begin
        if (!i_rstn)
          o_sync[g] <= 1'b0;
        else if (s2[g] == s3[g])
          o_sync[g] <= s3[g];
      end
    end
  endgenerate
endmodule

// *** core/pmc_buzz.sv ***
`timescale 1ns/1ps
// periodic one-cycle enable used to run core regulators intermittently
module pmc_buzz
  import pmc_pkg::*;
#(
  parameter int PERIOD = PMC_BUZZ_PERIOD
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_run,
  output logic o_pulse
);
  logic [7:0] cnt;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || !i_run)
    begin
      cnt <= 8'h00;
      o_pulse <= 1'b0;
    end
    else if (cnt == 8'(PERIOD - 1))
    begin
      cnt <= 8'h00;
      o_pulse <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      o_pulse <= 1'b0;
    end
  end
endmodule

// *** core/pmc_power_mode_controller.sv ***
`timescale 1ns/1ps
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NSUB = PMC_NUM_SUBSYS
)
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  // firmware mode request
  input wire logic i_mode_wr,
  input wire logic [2:0] i_mode_req,
  // templates
  input wire logic [NSUB-1:0] i_act_template,
  input wire logic [NSUB-1:0] i_alt_template,
  // firmware core regulator disables
  input wire logic i_dig_reg_dis,
  input wire logic i_ana_reg_dis,
  // interrupts (same clock domain)
  input wire logic i_irq_any,
  input wire logic i_irq_enabled,
  // asynchronous wakeup sources
  input wire logic [PMC_NUM_WK-1:0] i_wake_src,
  // asynchronous reset sources
  input wire logic i_external_reset_pin,
  input wire logic i_low_voltage_detect_rst,
  input wire logic i_watchdog_reset,
  // outputs
  output logic [1:0] o_mode,
  output logic [NSUB-1:0] o_clk_en,
  output logic [NSUB-1:0] o_bias_en,
  output logic o_i2c_en,
  output logic o_cmp_en,
  output logic o_low_speed_clk_en,
  output logic o_dig_reg_en,
  output logic o_ana_reg_en,
  output logic o_hib_reg_en,
  output logic o_sys_reset,
  output logic o_wakeup
);
  ////////////////////////////////////////////////////////////////////////////
  pmc_mode_t mode;
  pmc_mode_t next_mode;
  logic [PMC_NUM_WK-1:0] wake_s;
  logic [2:0] rst_s;
  logic cpu_off;
  logic next_cpu_off;
  logic cpu_tmpl_q;
  logic buzz;
  logic wake_evt;
  logic rst_evt;
  logic [PMC_CNT_W-1:0] lp_cnt;

  pmc_sync #(.WIDTH(PMC_NUM_WK)) u_wk_sync
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_async(i_wake_src),
    .o_sync(wake_s)
  );

  pmc_sync #(.WIDTH(3)) u_rst_sync
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_async({i_watchdog_reset, i_low_voltage_detect_rst, i_external_reset_pin}),
    .o_sync(rst_s)
  );

  pmc_buzz u_buzz
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_run(mode == PMC_SLEEP),
    .o_pulse(buzz)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wakeup and reset qualification per mode
  always_comb
  begin
    case (mode)
      PMC_ACTIVE: wake_evt = i_irq_any & i_irq_enabled;
      PMC_ALT_ACTIVE: wake_evt = i_irq_any;
      PMC_SLEEP: wake_evt = |wake_s;
      PMC_HIBERNATE: wake_evt = wake_s[PMC_WK_PIU];
      default: wake_evt = 1'b0;
    endcase
  end

  always_comb
  begin
    case (mode)
      PMC_SLEEP: rst_evt = |rst_s;
      PMC_HIBERNATE: rst_evt = rst_s[0];
      default: rst_evt = |rst_s;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing
  always_comb
  begin
    next_mode = mode;
    if (rst_evt || wake_evt)
      next_mode = PMC_ACTIVE;
    else if (i_mode_wr)
    begin
      case (i_mode_req)
        PMC_REQ_ACTIVE: next_mode = PMC_ACTIVE;
        PMC_REQ_ALT: next_mode = PMC_ALT_ACTIVE;
        PMC_REQ_SLEEP: next_mode = PMC_SLEEP;
        PMC_REQ_HIB: next_mode = PMC_HIBERNATE;
        default: next_mode = mode;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      mode <= PMC_ACTIVE;
    else
      mode <= next_mode;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      o_mode <= 2'h0;
    else
      o_mode <= next_mode;
  end

  // processor self-disable: a falling template bit turns it off until a wakeup,
  // after which it keeps running even though its template bit stays clear
  always_comb
  begin
    next_cpu_off = cpu_off;
    if (wake_evt || rst_evt)
      next_cpu_off = 1'b0;
    else if (cpu_tmpl_q && !i_act_template[PMC_CPU_BIT])
      next_cpu_off = 1'b1;
    else if (i_act_template[PMC_CPU_BIT])
      next_cpu_off = 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      cpu_off <= 1'b0;
      cpu_tmpl_q <= PMC_TEMPLATE_RST[PMC_CPU_BIT];
    end
    else
    begin
      cpu_off <= next_cpu_off;
      cpu_tmpl_q <= i_act_template[PMC_CPU_BIT];
    end
  end

  // cycles spent in a low-power mode, used to bound resume
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || mode == PMC_ACTIVE || mode == PMC_ALT_ACTIVE)
      lp_cnt <= '0;
    else if (lp_cnt != '1)
      lp_cnt <= lp_cnt + 1'b1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      o_wakeup <= 1'b0;
    else
      o_wakeup <= wake_evt && (mode != PMC_ACTIVE);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      o_sys_reset <= 1'b0;
    else
      o_sys_reset <= rst_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // subsystem enables, one generate iteration per subsystem
  genvar g;
  generate
    for (g = 0; g < NSUB; g++)
    begin : g_sub
      logic en;
      always_comb
      begin
        case (next_mode)
          PMC_ACTIVE: en = i_act_template[g];
          PMC_ALT_ACTIVE: en = i_alt_template[g];
          default: en = 1'b0;
        endcase
        if (g == PMC_CPU_BIT && next_mode == PMC_ACTIVE)
          en = !next_cpu_off;
      end

      always_ff @(posedge i_mclk)
      begin
        if (!i_rstn)
        begin
          o_clk_en[g] <= PMC_TEMPLATE_RST[g];
          o_bias_en[g] <= PMC_TEMPLATE_RST[g];
        end
        else
        begin
          o_clk_en[g] <= en;
          o_bias_en[g] <= en;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sleep resources (on in every mode but hibernate) and regulators
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_i2c_en <= 1'b1;
      o_cmp_en <= 1'b1;
      o_low_speed_clk_en <= 1'b1;
    end
    else
    begin
      o_i2c_en <= next_mode != PMC_HIBERNATE;
      o_cmp_en <= next_mode != PMC_HIBERNATE;
      o_low_speed_clk_en <= next_mode != PMC_HIBERNATE;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_dig_reg_en <= 1'b1;
      o_ana_reg_en <= 1'b1;
      o_hib_reg_en <= 1'b1;
    end
    else
    begin
      case (next_mode)
        PMC_HIBERNATE:
        begin
          o_dig_reg_en <= 1'b0;
          o_ana_reg_en <= 1'b0;
        end
        PMC_SLEEP:
        begin
          o_dig_reg_en <= buzz && !i_dig_reg_dis;
          o_ana_reg_en <= buzz && !i_ana_reg_dis;
        end
        default:
        begin
          o_dig_reg_en <= !i_dig_reg_dis;
          o_ana_reg_en <= !i_ana_reg_dis;
        end
      endcase
      o_hib_reg_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_reset_active;
    @(posedge i_mclk) !i_rstn |=> (o_mode == 2'h0);
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("not active after reset");

  property p_wake_active;
    @(posedge i_mclk) disable iff (!i_rstn) wake_evt |=> (mode == PMC_ACTIVE);
  endproperty
  a_wake_active: assert property (p_wake_active) else $error("wakeup did not give active");

  property p_wake_cpu;
    @(posedge i_mclk) disable iff (!i_rstn) wake_evt |=> o_clk_en[PMC_CPU_BIT];
  endproperty
  a_wake_cpu: assert property (p_wake_cpu) else $error("cpu not enabled on wakeup");

  property p_bad_req;
    @(posedge i_mclk) disable iff (!i_rstn)
      (i_mode_wr && i_mode_req > PMC_REQ_HIB && !wake_evt && !rst_evt) |=> $stable(mode);
  endproperty
  a_bad_req: assert property (p_bad_req) else $error("bad request changed mode");

  property p_active_tmpl;
    @(posedge i_mclk) disable iff (!i_rstn)
      (next_mode == PMC_ACTIVE) |=> (o_clk_en[NSUB-1:1] == $past(i_act_template[NSUB-1:1]));
  endproperty
  a_active_tmpl: assert property (p_active_tmpl) else $error("template not followed");

  property p_alt_tmpl;
    @(posedge i_mclk) disable iff (!i_rstn)
      (next_mode == PMC_ALT_ACTIVE) |=> (o_bias_en == $past(i_alt_template));
  endproperty
  a_alt_tmpl: assert property (p_alt_tmpl) else $error("alt template not followed");

  property p_sleep_off;
    @(posedge i_mclk) disable iff (!i_rstn)
      (mode == PMC_SLEEP && next_mode == PMC_SLEEP) |=> (o_clk_en == '0 && o_i2c_en && o_cmp_en);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep enables wrong");

  property p_hib_regs;
    @(posedge i_mclk) disable iff (!i_rstn)
      (next_mode == PMC_HIBERNATE) |=> (!o_dig_reg_en && !o_ana_reg_en && o_hib_reg_en
        && !o_low_speed_clk_en);
  endproperty
  a_hib_regs: assert property (p_hib_regs) else $error("hibernate regulators wrong");

  property p_hib_reset;
    @(posedge i_mclk) disable iff (!i_rstn)
      (mode == PMC_HIBERNATE && !rst_s[0] && rst_s[1]) |=> !o_sys_reset;
  endproperty
  a_hib_reset: assert property (p_hib_reset) else $error("reset honoured in hibernate");

  property p_sleep_resume;
    @(posedge i_mclk) disable iff (!i_rstn)
      (mode == PMC_SLEEP && |wake_s) |-> ##[1:2] (o_mode == 2'h0);
  endproperty
  a_sleep_resume: assert property (p_sleep_resume) else $error("slow sleep resume");

  c_sleep: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    mode == PMC_SLEEP ##1 mode == PMC_ACTIVE);
  c_hib: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    mode == PMC_HIBERNATE ##1 mode == PMC_ACTIVE);
  c_alt: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    mode == PMC_ALT_ACTIVE ##1 mode == PMC_ACTIVE);
  c_cpu_off: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    cpu_off ##1 !cpu_off && lp_cnt < PMC_CNT_W'(PMC_SLEEP_RESUME_CYC));
endmodule

// *** verification/pmc_power_mode_controller_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module pmc_power_mode_controller_tb_top
  import pmc_pkg::*;
;
  logic i_mclk;
  logic i_rstn;
  logic i_mode_wr;
  logic [2:0] i_mode_req;
  logic [7:0] i_act_template;
  logic [7:0] i_alt_template;
  logic i_dig_reg_dis;
  logic i_ana_reg_dis;
  logic i_irq_any;
  logic i_irq_enabled;
  logic [PMC_NUM_WK-1:0] i_wake_src;
  logic i_external_reset_pin;
  logic i_low_voltage_detect_rst;
  logic i_watchdog_reset;
  logic [1:0] o_mode;
  logic [7:0] o_clk_en;
  logic [7:0] o_bias_en;
  logic o_i2c_en;
  logic o_cmp_en;
  logic o_low_speed_clk_en;
  logic o_dig_reg_en;
  logic o_ana_reg_en;
  logic o_hib_reg_en;
  logic o_sys_reset;
  logic o_wakeup;
  int err_total;
  int n_compared;
  int seed;
  logic [1:0] m;
  logic cpu_on;
  logic [2:0] c;

  pmc_power_mode_controller uut
  (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_mode_wr(i_mode_wr),
    .i_mode_req(i_mode_req),
    .i_act_template(i_act_template),
    .i_alt_template(i_alt_template),
    .i_dig_reg_dis(i_dig_reg_dis),
    .i_ana_reg_dis(i_ana_reg_dis),
    .i_irq_any(i_irq_any),
    .i_irq_enabled(i_irq_enabled),
    .i_wake_src(i_wake_src),
    .i_external_reset_pin(i_external_reset_pin),
    .i_low_voltage_detect_rst(i_low_voltage_detect_rst),
    .i_watchdog_reset(i_watchdog_reset),
    .o_mode(o_mode),
    .o_clk_en(o_clk_en),
    .o_bias_en(o_bias_en),
    .o_i2c_en(o_i2c_en),
    .o_cmp_en(o_cmp_en),
    .o_low_speed_clk_en(o_low_speed_clk_en),
    .o_dig_reg_en(o_dig_reg_en),
    .o_ana_reg_en(o_ana_reg_en),
    .o_hib_reg_en(o_hib_reg_en),
    .o_sys_reset(o_sys_reset),
    .o_wakeup(o_wakeup)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

//////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask

  function automatic logic [7:0] exp_en(input logic [1:0] md);
    case (md)
      2'h0: exp_en = {i_act_template[7:1], cpu_on};
      2'h1: exp_en = i_alt_template;
      default: exp_en = 8'h00;
    endcase
  endfunction

  task automatic chk_state;
    logic [7:0] e;
    e = exp_en(m);
    `CHK("mode", m, o_mode)
    `CHK("clk_en", e, o_clk_en)
    `CHK("bias_en", e, o_bias_en)
    `CHK("i2c_en", m != 2'h3, o_i2c_en)
    `CHK("cmp_en", m != 2'h3, o_cmp_en)
    `CHK("lsclk_en", m != 2'h3, o_low_speed_clk_en)
    `CHK("hib_reg", 1'b1, o_hib_reg_en)
    if (m < 2'h2)
    begin
      `CHK("dig_reg", !i_dig_reg_dis, o_dig_reg_en)
      `CHK("ana_reg", !i_ana_reg_dis, o_ana_reg_en)
    end
    if (m == 2'h3)
    begin
      `CHK("dig_reg_hib", 1'b0, o_dig_reg_en)
      `CHK("ana_reg_hib", 1'b0, o_ana_reg_en)
    end
  endtask

  task automatic wr(input logic [2:0] rc);
    i_mode_wr = 1'b1;
    i_mode_req = rc;
    step(1);
    i_mode_wr = 1'b0;
    if (rc < 3'h4) m = rc[1:0];
  endtask

  // k below PMC_NUM_WK raises that source, otherwise an interrupt
  task automatic wake(input int k);
    int got;
    got = 0;
    if (k < PMC_NUM_WK) i_wake_src[k] = 1'b1;
    else i_irq_any = 1'b1;
    for (int i = 0; i < 12 && got == 0; i++)
    begin
      step(1);
      if (o_wakeup === 1'b1) got = 1;
    end
    `CHK("wake_mode", 2'h0, o_mode)
    `CHK("wake_cpu", 1'b1, o_clk_en[0])
    `CHK("wakeup", 1, got)
    i_wake_src = 6'h00;
    i_irq_any = 1'b0;
    m = 2'h0;
    cpu_on = 1'b1;
    step(8);
    chk_state;
  endtask

  task automatic quiet(input int n);
    int got;
    got = 0;
    repeat (n)
    begin
      step(1);
      if (o_wakeup === 1'b1 || o_sys_reset === 1'b1) got++;
    end
    `CHK("quiet", 0, got)
    chk_state;
  endtask

  task automatic rstev(input int k, input logic fire);
    int got;
    got = 0;
    {i_watchdog_reset, i_low_voltage_detect_rst, i_external_reset_pin} = 3'h1 << k;
    repeat (10)
    begin
      step(1);
      if (o_sys_reset === 1'b1) got++;
    end
    {i_watchdog_reset, i_low_voltage_detect_rst, i_external_reset_pin} = 3'h0;
    step(8);
    `CHK("sys_reset", fire, got != 0)
    `CHK("rst_clear", 1'b0, o_sys_reset)
    if (fire)
    begin
      m = 2'h0;
      cpu_on = 1'b1;
    end
    chk_state;
  endtask

  task automatic buzz(input int ed, input int ea);
    int nd;
    int na;
    nd = 0;
    na = 0;
    repeat (32)
    begin
      step(1);
      if (o_dig_reg_en === 1'b1) nd++;
      if (o_ana_reg_en === 1'b1) na++;
    end
    `CHK("dig_buzz", ed, nd)
    `CHK("ana_buzz", ea, na)
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

//////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    err_total++;
    tally_and_finish;
  end

  initial
  begin
    seed = 32'h85E4;
    err_total = 0;
    n_compared = 0;
    i_rstn = 1'b0;
    i_mode_wr = 1'b0;
    i_mode_req = 3'h0;
    i_act_template = 8'hFF;
    i_alt_template = 8'hFF;
    i_dig_reg_dis = 1'b0;
    i_ana_reg_dis = 1'b0;
    i_irq_any = 1'b0;
    i_irq_enabled = 1'b0;
    i_wake_src = 6'h00;
    {i_watchdog_reset, i_low_voltage_detect_rst, i_external_reset_pin} = 3'h0;
    m = 2'h0;
    cpu_on = 1'b1;
    step(12);
    i_rstn = 1'b1;
    chk_state;
    // every code once except 2 and 3, which are never written, then random codes with live template changes
    for (int n = 0; n < 48; n++)
    begin
      c = (n < 8) ? 3'(n) : 3'($random(seed));
      i_act_template = {7'($random(seed)), 1'b1};
      i_alt_template = {7'($random(seed)), 1'b1};
      i_dig_reg_dis = 1'($random(seed));
      i_ana_reg_dis = 1'($random(seed));
      if (c != 3'h2 && c != 3'h3) wr(c);
      step(2);
      chk_state;
    end
    wr(3'h0);
    i_dig_reg_dis = 1'b0;
    i_ana_reg_dis = 1'b0;
    i_irq_any = 1'b1;
    i_irq_enabled = 1'b1;
    quiet(10);
    i_irq_any = 1'b0;
    i_irq_enabled = 1'b0;
    wr(3'h1);
    step(2);
    wake(PMC_NUM_WK);
    i_act_template[0] = 1'b0;
    cpu_on = 1'b0;
    step(2);
    chk_state;
    for (int k = 0; k < PMC_NUM_WK; k++)
    begin
      wr(3'h2);
      step(1);
      chk_state;
      i_dig_reg_dis = (k == 1);
      buzz((k == 1) ? 0 : 32 / PMC_BUZZ_PERIOD, 32 / PMC_BUZZ_PERIOD);
      i_dig_reg_dis = 1'b0;
      wake(k);
    end
    i_act_template[0] = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      wr(3'h2);
      rstev(k, 1'b1);
    end
    rstev(2, 1'b1);
    wr(3'h3);
    step(1);
    chk_state;
    rstev(1, 1'b0);
    rstev(2, 1'b0);
    i_wake_src = 6'h3D;
    quiet(10);
    i_wake_src = 6'h00;
    step(6);
    wake(PMC_WK_PIU);
    wr(3'h3);
    rstev(0, 1'b1);
    wr(3'h1);
    i_rstn = 1'b0;
    step(2);
    i_rstn = 1'b1;
    m = 2'h0;
    step(1);
    chk_state;
    tally_and_finish;
  end
endmodule
